//--- verilog/bdie_pkg.sv
// bdie_pkg: constants and carrier types for the device event register block
// assumes a single 20 MHz clock domain and a plain register port
package bdie_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_EVENT_SET = 8'h00;
   localparam logic [7:0] OFF_EVENT_CLEAR = 8'h04;
   localparam logic [7:0] OFF_MASK_SET = 8'h08;
   localparam logic [7:0] OFF_MASK_CLEAR = 8'h0c;
   localparam logic [7:0] OFF_LINK_CONFIG = 8'h10;
   localparam logic [7:0] OFF_LINK_STATUS = 8'h14;

   // ---------------------------------------------------------------
   // event bit positions
   // ---------------------------------------------------------------
   localparam int BIT_LOCK_FAIL = 9;
   localparam int BIT_SELF_ID_DONE = 16;
   localparam int BIT_LINK_RESET = 17;
   localparam int BIT_PHY_IRQ = 19;
   localparam int BIT_CYCLE_BEGIN = 20;
   localparam int BIT_SECONDS_ROLL = 21;
   localparam int BIT_MISSING_CS = 22;
   localparam int BIT_CT_MISMATCH = 23;
   localparam int BIT_FATAL_HALT = 24;
   localparam int BIT_OVERLONG = 25;
   localparam int BIT_PHY_REG = 26;
   localparam int BIT_IMPL = 30;
   localparam int BIT_LINK_CFG_ROOT = 0;
   localparam int NUM_SRC = 11;
   localparam int CT_SECONDS_BIT = 7;

   // implemented event bits; others read zero
   localparam logic [31:0] EVENT_IMPL_MASK = 32'h07fb_0200;
   localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] LINK_CFG_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int OVERLONG_US = 125;
   // longest time, rounded down
   localparam int OVERLONG_CYCLES = OVERLONG_US * CLK_MHZ;
   localparam int OVL_W = 12;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bdie_bus_req_t;

   typedef struct packed {
      logic lock_response_failed;
      logic self_id_done;
      logic link_reset_seen;
      logic phy_irq;
      logic cycle_count_lsb;
      logic [6:0] cycle_seconds;
      logic cycle_start_seen;
      logic cycle_time_mismatch;
      logic fatal_halt;
      logic cycle_start_tx_begin;
      logic subaction_gap_end;
      logic phy_reg_byte_arrived;
      logic self_id_phase;
   } bdie_src_t;

   typedef enum logic [2:0] {
      OVL_IDLE = 3'b001,
      OVL_RUN = 3'b010,
      OVL_HIT = 3'b100
   } bdie_ovl_state_t;

endpackage

//--- verilog/bdie_edge.sv
// bdie_edge: rising edge detector over a vector of event sources
// assumes sources synchronous to mclk
`timescale 1ns/1ns
module bdie_edge #(
   parameter int WIDTH = 11
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] prev;
   } bdie_edge_state_t;

   bdie_edge_state_t st_reg;
   bdie_edge_state_t st_next;

   always_comb begin
      st_next.prev = level;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise = level & ~st_reg.prev;

endmodule // bdie_edge

//--- verilog/bdie_events.sv
// bdie_events: device event register with set/clear addresses and mask
// assumes sources synchronous to mclk; software on the plain register port
`timescale 1ns/1ns

// Functional notes
// - event bit sets on source rising edge or written one; clear-address ones clear
// - set-address read gives raw events; clear-address read gives events and mask
// - interrupt request high while any unmasked event bit is set
// - bit 9 sets when lock response got no ack_complete after retries
// - bit 16 sets when self-ID stream is complete
// - bit 16 forced to zero in the cycle a bus reset (hardware) sets bit 17; a software set of bit 17 leaves bit 16 alone
// - bit 17 sets when the PHY enters bus reset
// - clearing bit 17 is ignored during the self-ID phase
// - bit 19 sets on a PHY interrupt status transfer
// - bit 20 sets when cycle count low bit toggles
// - bit 21 sets when cycle seconds bit 6, the top bit of the 7-bit field, changes
// - bit 22 sets when no cycle start between two cycle begins
// - bit 23 sets on received cycle start time mismatch
// - bit 24 sets when an error halts a subunit
// - while bit 24 set and halt_blocks_context high, the lock fail event (bit 9) is blocked
// - as cycle root, bit 25 sets if a cycle exceeds 125 us
// - the overlong cycle event clears cycle root enable
// - bit 26 sets when a PHY register byte is available
module bdie_events #(
   parameter int OVL_CYCLES = bdie_pkg::OVERLONG_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire bdie_pkg::bdie_bus_req_t bus_req,
   output logic [31:0] rdata,
   input wire bdie_pkg::bdie_src_t src,
   input wire logic halt_blocks_context,
   output logic irq,
   output logic cycle_root_enable
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] interrupt_event;
      logic [31:0] interrupt_enable_mask;
      logic [31:0] link_config;
      logic [31:0] rdata;
      logic cycle_lsb_prev;
      logic seconds_bit_prev;
      logic level_init;
      logic cs_since_begin;
      logic [bdie_pkg::OVL_W-1:0] ovl_count;
      bdie_pkg::bdie_ovl_state_t ovl_state;
   } bdie_state_t;

   bdie_state_t st_reg;
   bdie_state_t st_next;

   logic [bdie_pkg::NUM_SRC-1:0] src_level;
   logic [bdie_pkg::NUM_SRC-1:0] src_rise;

   // ---------------------------------------------------------------
   // edge detection of level sources
   // ---------------------------------------------------------------
   // slot 4 spare, tied low
   assign src_level = {src.fatal_halt, src.cycle_time_mismatch, src.phy_irq,
                       src.link_reset_seen, src.lock_response_failed, src.self_id_done,
                       1'b0, src.cycle_start_tx_begin,
                       src.subaction_gap_end, src.cycle_start_seen, src.phy_reg_byte_arrived};

   bdie_edge #(
      .WIDTH(bdie_pkg::NUM_SRC)
   ) u_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .level(src_level),
      .rise(src_rise)
   );

   function automatic logic addr_hit(input bdie_pkg::bdie_bus_req_t r, input logic [7:0] off);
      addr_hit = (r.addr == off);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [31:0] hw_set;
      logic [31:0] sw_set;
      logic [31:0] sw_clr;
      logic cyc_begin;
      logic sec_change;
      logic ovl_event;
      logic lnk_rise;
      logic cs_seen_now;
      hw_set = '0;
      sw_set = '0;
      sw_clr = '0;
      st_next = st_reg;
      st_next.level_init = 1'b1;
      st_next.cycle_lsb_prev = src.cycle_count_lsb;
      st_next.seconds_bit_prev = src.cycle_seconds[6];
      cyc_begin = st_reg.level_init && (src.cycle_count_lsb != st_reg.cycle_lsb_prev);
      sec_change = st_reg.level_init && (src.cycle_seconds[6] != st_reg.seconds_bit_prev);
      lnk_rise = src_rise[7];
      cs_seen_now = src_rise[1];
      ovl_event = 1'b0;

      // overlong cycle watchdog, only while cycle root
      case (st_reg.ovl_state)
         bdie_pkg::OVL_IDLE: begin
            if (src_rise[3] && st_reg.link_config[bdie_pkg::BIT_LINK_CFG_ROOT]) begin
               st_next.ovl_state = bdie_pkg::OVL_RUN;
               st_next.ovl_count = '0;
            end
         end
         bdie_pkg::OVL_RUN: begin
            if (src_rise[2] || lnk_rise || !st_reg.link_config[bdie_pkg::BIT_LINK_CFG_ROOT]) begin
               st_next.ovl_state = bdie_pkg::OVL_IDLE;
            end else if (st_reg.ovl_count == bdie_pkg::OVL_W'(OVL_CYCLES - 1)) begin
               st_next.ovl_state = bdie_pkg::OVL_HIT;
            end else begin
               st_next.ovl_count = st_reg.ovl_count + 1'b1;
            end
         end
         bdie_pkg::OVL_HIT: begin
            ovl_event = 1'b1;
            st_next.ovl_state = bdie_pkg::OVL_IDLE;
         end
         default: begin
            st_next.ovl_state = bdie_pkg::OVL_IDLE;
         end
      endcase

      // missing cycle start between two cycle begins
      if (cyc_begin) begin
         hw_set[bdie_pkg::BIT_MISSING_CS] = !st_reg.cs_since_begin && !cs_seen_now;
         st_next.cs_since_begin = 1'b0;
      end else if (cs_seen_now || src_rise[3]) begin
         st_next.cs_since_begin = 1'b1;
      end

      hw_set[bdie_pkg::BIT_LOCK_FAIL] = src_rise[6];
      hw_set[bdie_pkg::BIT_SELF_ID_DONE] = src_rise[5];
      hw_set[bdie_pkg::BIT_LINK_RESET] = lnk_rise;
      hw_set[bdie_pkg::BIT_PHY_IRQ] = src_rise[8];
      hw_set[bdie_pkg::BIT_CYCLE_BEGIN] = cyc_begin;
      hw_set[bdie_pkg::BIT_SECONDS_ROLL] = sec_change;
      hw_set[bdie_pkg::BIT_CT_MISMATCH] = src_rise[9];
      hw_set[bdie_pkg::BIT_FATAL_HALT] = src_rise[10];
      hw_set[bdie_pkg::BIT_OVERLONG] = ovl_event;
      hw_set[bdie_pkg::BIT_PHY_REG] = src_rise[0];

      // halted context's lock fail event (bit 9) held off
      if (st_reg.interrupt_event[bdie_pkg::BIT_FATAL_HALT] && halt_blocks_context) begin
         hw_set[bdie_pkg::BIT_LOCK_FAIL] = 1'b0;
      end

      // register writes
      if (bus_req.wr) begin
         if (addr_hit(bus_req, bdie_pkg::OFF_EVENT_SET)) begin
            sw_set = bus_req.wdata;
         end
         if (addr_hit(bus_req, bdie_pkg::OFF_EVENT_CLEAR)) begin
            sw_clr = bus_req.wdata;
         end
         if (addr_hit(bus_req, bdie_pkg::OFF_MASK_SET)) begin
            st_next.interrupt_enable_mask = st_reg.interrupt_enable_mask |
                                            (bus_req.wdata & bdie_pkg::EVENT_IMPL_MASK);
         end
         if (addr_hit(bus_req, bdie_pkg::OFF_MASK_CLEAR)) begin
            st_next.interrupt_enable_mask = st_reg.interrupt_enable_mask & ~bus_req.wdata;
         end
         if (addr_hit(bus_req, bdie_pkg::OFF_LINK_CONFIG)) begin
            st_next.link_config = bus_req.wdata & 32'h0000_0001;
         end
      end
      if (src.self_id_phase) begin
         sw_clr[bdie_pkg::BIT_LINK_RESET] = 1'b0;
      end

      // set wins over clear; reserved bits stay zero
      st_next.interrupt_event = ((st_reg.interrupt_event & ~sw_clr) | hw_set | sw_set)
                                & bdie_pkg::EVENT_IMPL_MASK;
      if (hw_set[bdie_pkg::BIT_LINK_RESET]) begin
         st_next.interrupt_event[bdie_pkg::BIT_SELF_ID_DONE] = 1'b0;
      end
      if (ovl_event) begin
         st_next.link_config[bdie_pkg::BIT_LINK_CFG_ROOT] = 1'b0;
      end

      // read data, one cycle later
      st_next.rdata = '0;
      if (bus_req.rd) begin
         case (bus_req.addr)
            bdie_pkg::OFF_EVENT_SET: st_next.rdata = st_reg.interrupt_event;
            bdie_pkg::OFF_EVENT_CLEAR: st_next.rdata = st_reg.interrupt_event &
                                                       st_reg.interrupt_enable_mask;
            bdie_pkg::OFF_MASK_SET: st_next.rdata = st_reg.interrupt_enable_mask;
            bdie_pkg::OFF_MASK_CLEAR: st_next.rdata = st_reg.interrupt_enable_mask;
            bdie_pkg::OFF_LINK_CONFIG: st_next.rdata = st_reg.link_config;
            bdie_pkg::OFF_LINK_STATUS: st_next.rdata = {29'h0, st_reg.ovl_state};
            default: st_next.rdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg.interrupt_event <= bdie_pkg::EVENT_RESET;
         st_reg.interrupt_enable_mask <= bdie_pkg::MASK_RESET;
         st_reg.link_config <= bdie_pkg::LINK_CFG_RESET;
         st_reg.rdata <= '0;
         st_reg.cycle_lsb_prev <= 1'b0;
         st_reg.seconds_bit_prev <= 1'b0;
         st_reg.level_init <= 1'b0;
         st_reg.cs_since_begin <= 1'b1;
         st_reg.ovl_count <= '0;
         st_reg.ovl_state <= bdie_pkg::OVL_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign rdata = st_reg.rdata;
   assign irq = |(st_reg.interrupt_event & st_reg.interrupt_enable_mask);
   assign cycle_root_enable = st_reg.link_config[bdie_pkg::BIT_LINK_CFG_ROOT];

endmodule // bdie_events

//--- tb/bdie_events_sva.sv
// bdie_events_sva: port checks for the event register
// assumes bind onto bdie_events, one mclk domain
`timescale 1ns/1ns
module bdie_events_sva #(
   parameter int OVL_CYCLES = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire bdie_pkg::bdie_bus_req_t bus_req,
   input wire logic [31:0] rdata,
   input wire bdie_pkg::bdie_src_t src,
   input wire logic halt_blocks_context,
   input wire logic irq,
   input wire logic cycle_root_enable
);
   localparam logic [31:0] EV_BITS = 32'h07fb_0200;
   logic [15:0] ovl_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ------------
   // cycle watch
   // ------------
   always_ff @(posedge mclk) begin
      if (!rst_n || src.subaction_gap_end || src.link_reset_seen || !cycle_root_enable) begin
         ovl_cnt <= 16'h0;
      end else if ($rose(src.cycle_start_tx_begin)) begin
         ovl_cnt <= 16'h1;
      end else if (ovl_cnt != 16'h0) begin
         ovl_cnt <= ovl_cnt + 16'h1;
      end
   end
   sequence s_rd_set;
      bus_req.rd && bus_req.addr == bdie_pkg::OFF_EVENT_SET;
   endsequence
   sequence s_clr(int b);
      bus_req.wr && bus_req.addr == bdie_pkg::OFF_EVENT_CLEAR && bus_req.wdata[b];
   endsequence
   property p_rd_idle;
      !bus_req.rd |=> rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_rsv;
      bus_req.rd && bus_req.addr[7:3] == 5'h00 |=> (rdata & ~EV_BITS) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit read");
   property p_irq;
      bus_req.rd && bus_req.addr == bdie_pkg::OFF_EVENT_CLEAR |=> (rdata != 32'h0) == $past(irq);
   endproperty
   a_irq: assert property (p_irq) else $error("irq disagrees");
   property p_phy_set;
      $rose(src.phy_irq) ##[2:4] s_rd_set |=> rdata[19];
   endproperty
   a_phy_set: assert property (p_phy_set) else $error("phy event lost");
   property p_bus_reset;
      $rose(src.link_reset_seen) ##[2:4] s_rd_set |=> rdata[17] && !rdata[16];
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset event");
   property p_sid_hold;
      s_rd_set ##1 rdata[17] ##1 s_clr(17) ##0 src.self_id_phase ##2 s_rd_set |=> rdata[17];
   endproperty
   a_sid_hold: assert property (p_sid_hold) else $error("cleared in phase");
   property p_clear;
      s_rd_set ##1 rdata[19] ##1 s_clr(19) ##0 !src.phy_irq ##2 s_rd_set |=> !rdata[19];
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_root_drop;
      ovl_cnt == OVL_CYCLES + 2 |-> !cycle_root_enable;
   endproperty
   a_root_drop: assert property (p_root_drop) else $error("root kept");
endmodule // bdie_events_sva

bind bdie_events bdie_events_sva #(.OVL_CYCLES(OVL_CYCLES)) u_sva (.mclk(mclk), .rst_n(rst_n),
   .bus_req(bus_req), .rdata(rdata), .src(src), .halt_blocks_context(halt_blocks_context),
   .irq(irq), .cycle_root_enable(cycle_root_enable));

//--- tb/bdie_src_model.sv
// bdie_src_model: link and phy event sources
// assumes kick bits in event bit positions, one cycle long
`timescale 1ns/1ns
module bdie_src_model (
   input wire logic mclk,
   input wire logic [31:0] kick,
   input wire logic sid_phase,
   output bdie_pkg::bdie_src_t src
);
   initial src = '0;
   always @(posedge mclk) begin
      src.lock_response_failed <= kick[9];
      src.self_id_done <= kick[16];
      src.link_reset_seen <= kick[17];
      src.phy_irq <= kick[19];
      src.cycle_count_lsb <= src.cycle_count_lsb ^ kick[20];
      src.cycle_seconds[6] <= src.cycle_seconds[6] ^ kick[21];
      src.cycle_start_seen <= kick[22];
      src.cycle_time_mismatch <= kick[23];
      src.fatal_halt <= kick[24];
      src.cycle_start_tx_begin <= kick[25];
      src.phy_reg_byte_arrived <= kick[26];
      src.subaction_gap_end <= kick[27];
      src.self_id_phase <= sid_phase;
   end
endmodule // bdie_src_model

//--- tb/bus_device_interrupt_events_tb.sv
// bus_device_interrupt_events_tb: scenario bench
// assumes bdie_events, bdie_src_model and bound checker
`timescale 1ns/1ns
module bus_device_interrupt_events_tb;
   localparam int OVL = 8;
   localparam logic [7:0] ES = bdie_pkg::OFF_EVENT_SET;
   localparam logic [7:0] EC = bdie_pkg::OFF_EVENT_CLEAR;
   logic mclk;
   logic rst_n;
   bdie_pkg::bdie_bus_req_t bus;
   bdie_pkg::bdie_src_t src;
   logic [31:0] rdata;
   logic [31:0] kick;
   logic sid_phase;
   logic halt;
   logic irq;
   logic root;
   int error_cnt;
   int n_checks;
   bdie_src_model u_src (.mclk(mclk), .kick(kick), .sid_phase(sid_phase), .src(src));
   bdie_events #(.OVL_CYCLES(OVL)) DUT (.mclk(mclk), .rst_n(rst_n), .bus_req(bus), .rdata(rdata),
      .src(src), .halt_blocks_context(halt), .irq(irq), .cycle_root_enable(root));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask
   task automatic pulse(input int b);
      @(posedge mclk);
      kick <= 32'h1 << b;
      @(posedge mclk);
      kick <= 32'h0;
      @(posedge mclk);
   endtask
   task automatic t_sources();
      int bits[8] = '{9, 16, 17, 19, 21, 23, 24, 26};
      rd(ES, 32'h0, "reset");
      foreach (bits[i]) begin
         pulse(bits[i]);
         rd(ES, 32'h1 << bits[i], "src");
         wr(EC, 32'hffff_ffff);
         rd(ES, 32'h0, "cleared");
      end
   endtask
   task automatic t_cycle();
      pulse(20);
      rd(ES, 32'h0010_0000, "begin");
      wr(EC, 32'hffff_ffff);
      pulse(20);
      rd(ES, 32'h0050_0000, "lost");
      wr(EC, 32'hffff_ffff);
      pulse(22);
      pulse(20);
      rd(ES, 32'h0010_0000, "seen");
      wr(EC, 32'hffff_ffff);
   endtask
   task automatic t_sid();
      @(posedge mclk);
      sid_phase <= 1'b1;
      pulse(16);
      rd(ES, 32'h1 << 16, "sid");
      pulse(17);
      rd(ES, 32'h1 << 17, "reset");
      wr(EC, 32'h1 << 17);
      rd(ES, 32'h1 << 17, "held");
      @(posedge mclk);
      sid_phase <= 1'b0;
      wr(EC, 32'h1 << 17);
      rd(ES, 32'h0, "released");
   endtask
   task automatic t_mask();
      wr(ES, 32'hffff_ffff);
      rd(ES, 32'h07fb_0200, "soft set");
      chk("irq", 32'h0, {31'h0, irq});
      wr(bdie_pkg::OFF_MASK_SET, 32'h1 << 19);
      #1 chk("irq", 32'h1, {31'h0, irq});
      rd(bdie_pkg::OFF_MASK_SET, 32'h1 << 19, "mask");
      rd(EC, 32'h1 << 19, "masked");
      wr(EC, 32'h1 << 19);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(bdie_pkg::OFF_MASK_CLEAR, 32'hffff_ffff);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0, "unmapped");
      rd(ES, 32'h07f3_0200, "kept");
      wr(EC, 32'hffff_ffff);
   endtask
   task automatic t_halt();
      wr(ES, 32'h1 << 24);
      @(posedge mclk);
      halt <= 1'b1;
      pulse(9);
      rd(ES, 32'h1 << 24, "blocked");
      @(posedge mclk);
      halt <= 1'b0;
      wr(EC, 32'hffff_ffff);
   endtask
   task automatic t_ovl();
      wr(bdie_pkg::OFF_LINK_CONFIG, 32'h1);
      #1 chk("root", 32'h1, {31'h0, root});
      pulse(25);
      repeat (OVL + 6) @(posedge mclk);
      rd(ES, 32'h1 << 25, "overlong");
      chk("root", 32'h0, {31'h0, root});
      wr(EC, 32'hffff_ffff);
      wr(bdie_pkg::OFF_LINK_CONFIG, 32'h1);
      pulse(25);
      pulse(27);
      repeat (OVL + 6) @(posedge mclk);
      rd(ES, 32'h0, "gap");
      chk("root", 32'h1, {31'h0, root});
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      bus = '0;
      kick = 32'h0;
      sid_phase = 1'b0;
      halt = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_sources();
      t_cycle();
      t_sid();
      t_mask();
      t_halt();
      t_ovl();
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end
endmodule // bus_device_interrupt_events_tb
